// *** pkg/sector_guard_pkg.sv ***
// sector guard package: register offsets, status fields, opcodes, protection modes and timing
// assumes a 40 MHz device clock and a 32-bit word-aligned register port
`default_nettype none
package sector_guard_pkg;

    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA_LO = 8'h08;
    localparam logic [7:0] REG_DATA_HI = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RESULT_LO = 8'h14;
    localparam logic [7:0] REG_RESULT_HI = 8'h18;

    // --------------------------------------------------------------
    // primary status register field positions
    // --------------------------------------------------------------
    localparam int ST_WIP = 0;
    localparam int ST_PERR = 1;
    localparam int ST_WEL = 2;
    localparam int ST_LOCK = 3;
    localparam int ST_MODE_LO = 4;

    // --------------------------------------------------------------
    // command opcodes written to the command register
    // --------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] CMD_SW_RESET = 8'hf0;
    localparam logic [7:0] CMD_GUARD_PROG = 8'h2f;
    localparam logic [7:0] CMD_GUARD_READ = 8'h2b;
    localparam logic [7:0] CMD_PPB_PROG = 8'he3;
    localparam logic [7:0] CMD_PPB_ERASE = 8'he4;
    localparam logic [7:0] CMD_PPB_READ = 8'he2;
    localparam logic [7:0] CMD_DYB_WRITE = 8'he1;
    localparam logic [7:0] CMD_DYB_READ = 8'he0;
    localparam logic [7:0] CMD_LOCK_CLEAR = 8'ha6;
    localparam logic [7:0] CMD_LOCK_READ = 8'ha7;
    localparam logic [7:0] CMD_PWD_PROG = 8'he8;
    localparam logic [7:0] CMD_PWD_READ = 8'he7;
    localparam logic [7:0] CMD_PWD_UNLOCK = 8'he9;
    localparam logic [7:0] CMD_ARRAY_PROG = 8'h02;
    localparam logic [7:0] CMD_ARRAY_ERASE = 8'hd8;

    // --------------------------------------------------------------
    // protection mode field codes
    // --------------------------------------------------------------
    localparam logic [1:0] MODE_NONE = 2'h3;
    localparam logic [1:0] MODE_PERSIST = 2'h2;
    localparam logic [1:0] MODE_PASSWORD = 2'h1;
    localparam logic [1:0] MODE_ILLEGAL = 2'h0;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int PENALTY_US = 100;
    localparam int PENALTY_TOL_US = 20;
    localparam int PENALTY_CYCLES = PENALTY_US * CLK_MHZ;
    localparam int UNLOCK_OK_CYCLES = 1;
    localparam int CNT_W = 20;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } seq_type;

endpackage
`default_nettype wire

// *** hw/sector_guard.sv ***
// sector guard: protection mode field, persistent and dynamic sector bits, lock bit and password unlock
// assumes a command sequencer on the same clock writing the register port; hardware reset pin is asynchronous
//
// Overview of operation
// - mode field 11 default persistent, 10 persistent, 01 password.
// - programming mode field to 00 is refused with a program error.
// - once a mode bit is programmed the mode field never changes again.
// - write-in-progress stays high for the program time of the mode field.
// - program or erase on a protected sector is refused.
// - persistent bits program singly to zero and erase together to one.
// - persistent program or erase with lock clear fails, bits unchanged.
// - dynamic write sets or clears one sector bit; zero means protected.
// - dynamic bits return to unprotected on power, software or hardware reset.
// - lock bit zero blocks persistent bit changes, one allows them.
// - lock clear command drives the lock bit to zero.
// - persistent mode: hardware reset sets lock; software reset leaves it.
// - password mode: hardware reset clears lock; only unlock sets it.
// - sector protected unless both bits are one; dynamic bits always writable.
// - unlock compares all 64 bits; exact match sets the lock bit.
// - mismatch sets program error, keeps busy, lock stays zero.
// - unlock attempts spaced by a 100 us busy penalty.
// - matching password ends busy without the penalty.
// - password mode ignores password read and program silently.
// - password programming only clears bits; no error for ones.
// - password storage starts all ones and is reached only by its commands.
// - unconfigured device runs persistent mode with every sector unprotected.
// - final protection is block-protect result OR sector bit result.
// - non-volatile changes need the write enable latch set.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module sector_guard #(
    parameter int SECTORS = 256,
    parameter int ADDR_W = 24,
    parameter int PROG_CYCLES = 1000,
    parameter int ERASE_CYCLES = 40000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hwResetN,
    input wire sector_guard_pkg::bus_req_type bus,
    input wire logic [SECTORS-1:0] blockProtect,
    output logic [31:0] rdData,
    output logic [SECTORS-1:0] protectMap,
    output logic busy
);

    localparam int SECT_W = $clog2(SECTORS);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (SECTORS < 2 || (1 << SECT_W) != SECTORS || ADDR_W < SECT_W || ADDR_W > 32) begin : g_bad_geometry
        $error("sector_guard: sector count must be a power of two fitting the address");
    end
    if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || PROG_CYCLES >= (1 << sector_guard_pkg::CNT_W)
        || ERASE_CYCLES >= (1 << sector_guard_pkg::CNT_W)) begin : g_bad_timing
        $error("sector_guard: busy times must fit the busy counter");
    end

    // ------------------------------------------------------------------
    // whole state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        sector_guard_pkg::seq_type seq;
        logic [sector_guard_pkg::CNT_W-1:0] cnt;
        logic [1:0] mode;
        logic [SECTORS-1:0] persistent_sector_bit;
        logic [SECTORS-1:0] dynamic_sector_bit;
        logic lock;
        logic write_enable_latch;
        logic write_in_progress;
        logic perr;
        logic [63:0] pwd;
        logic [ADDR_W-1:0] addr;
        logic [63:0] data;
        logic [63:0] result;
        logic [31:0] rdData;
        logic [SECTORS-1:0] protectMap;
        logic [1:0] hwSync;
    } state_type;

    state_type s;
    state_type next_s;

    logic [SECT_W-1:0] sect;
    logic cmdHit;
    logic hwActive;
    logic pwMode;
    logic guarded;
    logic start;
    logic [sector_guard_pkg::CNT_W-1:0] len;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        sect = s.addr[ADDR_W-1 -: SECT_W];
        cmdHit = bus.wr && bus.addr == sector_guard_pkg::REG_CMD && s.seq == sector_guard_pkg::SEQ_IDLE;
        hwActive = ~s.hwSync[1];
        pwMode = s.mode == sector_guard_pkg::MODE_PASSWORD;
        guarded = blockProtect[sect] | ~(s.persistent_sector_bit[sect] & s.dynamic_sector_bit[sect]);
        start = 1'b0;
        len = sector_guard_pkg::CNT_W'(PROG_CYCLES);
        next_s.rdData = 32'h0000_0000;
        // pin passes two flops; only the second is looked at
        next_s.hwSync = {s.hwSync[0], hwResetN};
        // final protection per sector, registered so the output is a flop
        next_s.protectMap = blockProtect | ~(s.persistent_sector_bit & s.dynamic_sector_bit);

        // operand registers are writable at any time
        if (bus.wr && bus.addr == sector_guard_pkg::REG_ADDR) begin
            next_s.addr = bus.wdata[ADDR_W-1:0];
        end
        if (bus.wr && bus.addr == sector_guard_pkg::REG_DATA_LO) begin
            next_s.data[31:0] = bus.wdata;
        end
        if (bus.wr && bus.addr == sector_guard_pkg::REG_DATA_HI) begin
            next_s.data[63:32] = bus.wdata;
        end

        // busy timer: commands are dropped until write-in-progress falls
        if (s.seq == sector_guard_pkg::SEQ_BUSY) begin
            if (s.cnt <= sector_guard_pkg::CNT_W'(1)) begin
                next_s.seq = sector_guard_pkg::SEQ_IDLE;
                next_s.write_in_progress = 1'b0;
                next_s.cnt = '0;
            end else begin
                next_s.cnt = s.cnt - sector_guard_pkg::CNT_W'(1);
            end
        end

        // command execution; effects land at acceptance, busy then times the operation
        if (cmdHit) begin
            case (bus.wdata[7:0])
                sector_guard_pkg::CMD_WRITE_ENABLE_COMMAND: begin
                    next_s.write_enable_latch = 1'b1;
                end
                sector_guard_pkg::CMD_WRDI: begin
                    next_s.write_enable_latch = 1'b0;
                end
                sector_guard_pkg::CMD_CLEAR_STATUS: begin
                    next_s.perr = 1'b0;
                end
                sector_guard_pkg::CMD_SW_RESET: begin
                    next_s.dynamic_sector_bit = '1;
                    next_s.write_enable_latch = 1'b0;
                    next_s.perr = 1'b0;
                    // lock bit deliberately untouched by a software reset
                end
                sector_guard_pkg::CMD_GUARD_PROG: begin
                    if (s.write_enable_latch) begin
                        next_s.write_enable_latch = 1'b0;
                        start = 1'b1;
                        if (s.mode != sector_guard_pkg::MODE_NONE) begin
                            next_s.perr = 1'b1;
                        end else if ((s.mode & s.data[2:1]) == sector_guard_pkg::MODE_ILLEGAL) begin
                            next_s.perr = 1'b1;
                        end else begin
                            next_s.mode = s.mode & s.data[2:1];
                        end
                    end
                end
                sector_guard_pkg::CMD_GUARD_READ: begin
                    next_s.result = {61'h0, s.mode, 1'b0};
                end
                sector_guard_pkg::CMD_PPB_PROG: begin
                    if (s.write_enable_latch) begin
                        next_s.write_enable_latch = 1'b0;
                        start = 1'b1;
                        if (!s.lock) begin
                            next_s.perr = 1'b1;
                        end else begin
                            next_s.persistent_sector_bit[sect] = 1'b0;
                        end
                    end
                end
                sector_guard_pkg::CMD_PPB_ERASE: begin
                    if (s.write_enable_latch) begin
                        next_s.write_enable_latch = 1'b0;
                        start = 1'b1;
                        len = sector_guard_pkg::CNT_W'(ERASE_CYCLES);
                        if (!s.lock) begin
                            next_s.perr = 1'b1;
                        end else begin
                            // pre-program and verify are internal; only the outcome is modelled
                            next_s.persistent_sector_bit = '1;
                        end
                    end
                end
                sector_guard_pkg::CMD_PPB_READ: begin
                    next_s.result = {63'h0, s.persistent_sector_bit[sect]};
                end
                sector_guard_pkg::CMD_DYB_WRITE: begin
                    next_s.dynamic_sector_bit[sect] = s.data[0];
                end
                sector_guard_pkg::CMD_DYB_READ: begin
                    next_s.result = {63'h0, s.dynamic_sector_bit[sect]};
                end
                sector_guard_pkg::CMD_LOCK_CLEAR: begin
                    next_s.lock = 1'b0;
                end
                sector_guard_pkg::CMD_LOCK_READ: begin
                    next_s.result = {63'h0, s.lock};
                end
                sector_guard_pkg::CMD_PWD_PROG: begin
                    // silently dropped once password mode is chosen
                    if (!pwMode && s.write_enable_latch) begin
                        next_s.write_enable_latch = 1'b0;
                        start = 1'b1;
                        next_s.pwd = s.pwd & s.data;
                    end
                end
                sector_guard_pkg::CMD_PWD_READ: begin
                    if (!pwMode) begin
                        next_s.result = s.pwd;
                    end
                end
                sector_guard_pkg::CMD_PWD_UNLOCK: begin
                    // persistent mode raises the lock only at power-up or hardware reset, so unlock is dropped there
                    if (pwMode) begin
                        start = 1'b1;
                        if (s.data == s.pwd) begin
                            next_s.lock = 1'b1;
                            len = sector_guard_pkg::CNT_W'(sector_guard_pkg::UNLOCK_OK_CYCLES);
                        end else begin
                            // penalty spacing makes a search of the key space hopeless
                            next_s.perr = 1'b1;
                            len = sector_guard_pkg::CNT_W'(sector_guard_pkg::PENALTY_CYCLES);
                        end
                    end
                end
                sector_guard_pkg::CMD_ARRAY_PROG,
                sector_guard_pkg::CMD_ARRAY_ERASE: begin
                    if (s.write_enable_latch) begin
                        next_s.write_enable_latch = 1'b0;
                        start = 1'b1;
                        if (bus.wdata[7:0] == sector_guard_pkg::CMD_ARRAY_ERASE) begin
                            len = sector_guard_pkg::CNT_W'(ERASE_CYCLES);
                        end
                        if (guarded) begin
                            next_s.perr = 1'b1;
                        end
                    end
                end
                default: begin
                    // unknown opcodes are ignored
                end
            endcase
        end

        if (start) begin
            next_s.seq = sector_guard_pkg::SEQ_BUSY;
            next_s.write_in_progress = 1'b1;
            next_s.cnt = len;
        end

        // register reads: data stand in the cycle after the strobe only
        if (bus.rd) begin
            case (bus.addr)
                sector_guard_pkg::REG_ADDR: begin
                    next_s.rdData = 32'(s.addr);
                end
                sector_guard_pkg::REG_DATA_LO: begin
                    next_s.rdData = s.data[31:0];
                end
                sector_guard_pkg::REG_DATA_HI: begin
                    next_s.rdData = s.data[63:32];
                end
                sector_guard_pkg::REG_STATUS: begin
                    next_s.rdData[sector_guard_pkg::ST_WIP] = s.write_in_progress;
                    next_s.rdData[sector_guard_pkg::ST_PERR] = s.perr;
                    next_s.rdData[sector_guard_pkg::ST_WEL] = s.write_enable_latch;
                    next_s.rdData[sector_guard_pkg::ST_LOCK] = s.lock;
                    next_s.rdData[sector_guard_pkg::ST_MODE_LO +: 2] = s.mode;
                end
                sector_guard_pkg::REG_RESULT_LO: begin
                    next_s.rdData = s.result[31:0];
                end
                sector_guard_pkg::REG_RESULT_HI: begin
                    next_s.rdData = s.result[63:32];
                end
                default: begin
                    next_s.rdData = 32'h0000_0000;
                end
            endcase
        end

        // hardware reset pin: volatile state only, lock follows the mode
        if (hwActive) begin
            next_s.dynamic_sector_bit = '1;
            next_s.lock = ~pwMode;
            next_s.write_enable_latch = 1'b0;
            next_s.write_in_progress = 1'b0;
            next_s.perr = 1'b0;
            next_s.seq = sector_guard_pkg::SEQ_IDLE;
            next_s.cnt = '0;
        end
    end

    // ------------------------------------------------------------------
    // state register; rst stands for first power-up of a blank part
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s.seq <= sector_guard_pkg::SEQ_IDLE;
            s.cnt <= '0;
            s.mode <= sector_guard_pkg::MODE_NONE;
            s.persistent_sector_bit <= '1;
            s.dynamic_sector_bit <= '1;
            s.lock <= 1'b1;
            s.write_enable_latch <= 1'b0;
            s.write_in_progress <= 1'b0;
            s.perr <= 1'b0;
            s.pwd <= '1;
            s.addr <= '0;
            s.data <= '0;
            s.result <= '0;
            s.rdData <= 32'h0000_0000;
            s.protectMap <= '0;
            s.hwSync <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

    assign rdData = s.rdData;
    assign protectMap = s.protectMap;
    assign busy = s.write_in_progress;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence unlockTry;
        cmdHit && bus.wdata[7:0] == sector_guard_pkg::CMD_PWD_UNLOCK && pwMode && !hwActive;
    endsequence

    sequence unlockMiss;
        unlockTry ##0 s.data != s.pwd;
    endsequence

    sequence unlockHit;
        unlockTry ##0 s.data == s.pwd;
    endsequence

    sequence hwPulse;
        hwActive ##1 !hwActive;
    endsequence

    a_mode_frozen: assert property (s.mode != sector_guard_pkg::MODE_NONE |=> s.mode == $past(s.mode))
        else $error("mode field changed after selection");

    a_mode_legal: assert property (s.mode != sector_guard_pkg::MODE_ILLEGAL)
        else $error("mode field reached illegal value");

    a_miss_penalty: assert property (unlockMiss |=> s.write_in_progress && s.perr && !s.lock
        && s.cnt == sector_guard_pkg::CNT_W'(sector_guard_pkg::PENALTY_CYCLES))
        else $error("password mismatch did not start penalty");

    a_hit_fast: assert property (unlockHit |=> s.lock && s.write_in_progress ##1 !s.write_in_progress)
        else $error("password match did not release quickly");

    a_dyb_restore: assert property (hwPulse |-> &s.dynamic_sector_bit)
        else $error("dynamic bits not unprotected after hardware reset");

    a_lock_follows: assert property (hwPulse |-> s.lock == (s.mode != sector_guard_pkg::MODE_PASSWORD))
        else $error("lock bit wrong after hardware reset");

    a_ppb_guarded: assert property (s.persistent_sector_bit != $past(s.persistent_sector_bit) |-> $past(s.lock) && $past(s.write_enable_latch))
        else $error("persistent bits changed while locked or without write enable");

    a_lock_rises: assert property (s.lock && !$past(s.lock) && !$past(hwActive) |-> $past(pwMode))
        else $error("lock bit raised by a command outside password mode");

    a_pwd_clears: assert property ((s.pwd & ~$past(s.pwd)) == 64'h0)
        else $error("password bit went from zero to one");

    a_guard_refuse: assert property (cmdHit && s.write_enable_latch && guarded && !hwActive
        && bus.wdata[7:0] == sector_guard_pkg::CMD_ARRAY_PROG |=> s.perr && s.write_in_progress)
        else $error("program to protected sector not refused");

    a_busy_drop: assert property (s.write_in_progress && bus.wr && bus.addr == sector_guard_pkg::REG_CMD
        && bus.wdata[7:0] == sector_guard_pkg::CMD_LOCK_CLEAR && !hwActive && s.cnt > 1 && s.lock |=> s.lock)
        else $error("command accepted while busy");

endmodule // sector_guard
`default_nettype wire

// *** testbench/sector_guard_host.sv ***
// host model: issues register-port requests as the command controller would
// assumes strobes sampled at rising clk and read data valid one cycle later
`timescale 1ns/1ps
`default_nettype none
module sector_guard_host (
    input wire logic clk,
    input wire logic [31:0] rdData,
    output var sector_guard_pkg::bus_req_type bus
);
    initial bus = '0;
    // one strobe cycle, held to its sampling edge; read data taken in the cycle after
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] r);
        @(posedge clk);
        bus <= '{a, d, w, !w};
        @(posedge clk);
        bus <= '0;
        #1 r = rdData;
    endtask
endmodule // sector_guard_host
`default_nettype wire

// *** testbench/sector_guard_tb_top.sv ***
// bench for the sector guard: host model sends commands, status and map are checked
// assumes 16 sectors and shortened program and erase counts
`timescale 1ns/1ps
`default_nettype none
module sector_guard_tb_top;
    logic clk, rst, hwResetN, busy;
    logic [15:0] blockProtect, protectMap, oh;
    logic [31:0] rdData, q, lo;
    logic [63:0] pw;
    logic [3:0] s;
    sector_guard_pkg::bus_req_type bus;
    int error_cnt, checks_done, cyc, n;
    sector_guard #(.SECTORS(16), .ADDR_W(24), .PROG_CYCLES(4), .ERASE_CYCLES(8)) i_dut (.clk(clk), .rst(rst),
        .hwResetN(hwResetN), .bus(bus), .blockProtect(blockProtect), .rdData(rdData),
        .protectMap(protectMap), .busy(busy));
    sector_guard_host i_host (.clk(clk), .rdData(rdData), .bus(bus));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] sv(input logic [1:0] m, input logic [3:0] f);
        return {26'h0, m, f};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [7:0] c);
        i_host.xfer(sector_guard_pkg::REG_CMD, {24'h0, c}, 1'b1, q);
    endtask
    // read-type command, then the low result word against what the rules give
    task automatic rr(input logic [7:0] c, input logic [31:0] e);
        op(c);
        i_host.xfer(sector_guard_pkg::REG_RESULT_LO, 32'h0, 1'b0, q);
        chk(q, e);
    endtask
    // write enable first when asked, then the operand, then the command
    task automatic run(input logic [7:0] c, input logic [63:0] d, input logic w);
        if (w) op(sector_guard_pkg::CMD_WRITE_ENABLE_COMMAND);
        i_host.xfer(sector_guard_pkg::REG_DATA_LO, d[31:0], 1'b1, q);
        i_host.xfer(sector_guard_pkg::REG_DATA_HI, d[63:32], 1'b1, q);
        op(c);
    endtask
    // latch bit masked by default since its timing on refused commands is open
    task automatic st(input logic [31:0] e, input logic [31:0] m = 32'h3b);
        i_host.xfer(sector_guard_pkg::REG_STATUS, 32'h0, 1'b0, q);
        chk(q & m, e & m);
    endtask
    task automatic map(input logic [15:0] e);
        @(posedge clk);
        #1 chk(protectMap, e);
    endtask
    // counts busy cycles so penalty lengths can be judged
    task automatic idle;
        n = 0;
        while (busy !== 1'b0 && n < 6000) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic hw;
        @(posedge clk);
        hwResetN <= 1'b0;
        repeat (3) @(posedge clk);
        hwResetN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // clock, ceiling and sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // the unlock penalty dominates the run, about 4000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    initial begin
        rst = 1'b1;
        hwResetN = 1'b1;
        blockProtect = '0;
        error_cnt = 0;
        checks_done = 0;
        q = $urandom(32'h06f1);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        st(sv(2'h3, 4'h8), 32'h3f);
        map(16'h0);
        op(sector_guard_pkg::CMD_WRITE_ENABLE_COMMAND);
        st(sv(2'h3, 4'hc), 32'h3f);
        op(sector_guard_pkg::CMD_WRDI);
        st(sv(2'h3, 4'h8), 32'h3f);
        i_host.xfer(8'h1c, 32'h0, 1'b0, q);
        chk(q, 32'h0);
        @(posedge clk);
        blockProtect <= 16'($urandom);
        #1 map(blockProtect);
        @(posedge clk);
        blockProtect <= 16'h0;
        s = 4'($urandom);
        oh = 16'h1 << s;
        i_host.xfer(sector_guard_pkg::REG_ADDR, {8'h0, s, 20'h0}, 1'b1, q);
        run(sector_guard_pkg::CMD_DYB_WRITE, 64'h0, 1'b0);
        map(oh);
        rr(sector_guard_pkg::CMD_DYB_READ, 32'h0);
        run(sector_guard_pkg::CMD_DYB_WRITE, 64'h1, 1'b0);
        map(16'h0);
        run(sector_guard_pkg::CMD_DYB_WRITE, 64'h0, 1'b0);
        op(sector_guard_pkg::CMD_SW_RESET);
        map(16'h0);
        op(sector_guard_pkg::CMD_PPB_PROG);
        st(sv(2'h3, 4'h8), 32'h3f);
        run(sector_guard_pkg::CMD_PPB_PROG, 64'h0, 1'b1);
        idle;
        map(oh);
        rr(sector_guard_pkg::CMD_PPB_READ, 32'h0);
        run(sector_guard_pkg::CMD_ARRAY_PROG, 64'h0, 1'b1);
        idle;
        st(sv(2'h3, 4'ha));
        op(sector_guard_pkg::CMD_CLEAR_STATUS);
        run(sector_guard_pkg::CMD_PPB_ERASE, 64'h0, 1'b1);
        idle;
        map(16'h0);
        run(sector_guard_pkg::CMD_ARRAY_ERASE, 64'h0, 1'b1);
        idle;
        chk(n, 64'h8);
        st(sv(2'h3, 4'h8));
        op(sector_guard_pkg::CMD_LOCK_CLEAR);
        st(sv(2'h3, 4'h0));
        rr(sector_guard_pkg::CMD_LOCK_READ, 32'h0);
        run(sector_guard_pkg::CMD_PPB_PROG, 64'h0, 1'b1);
        idle;
        st(sv(2'h3, 4'h2));
        map(16'h0);
        run(sector_guard_pkg::CMD_DYB_WRITE, 64'h0, 1'b0);
        map(oh);
        op(sector_guard_pkg::CMD_SW_RESET);
        st(sv(2'h3, 4'h0));
        hw;
        st(sv(2'h3, 4'h8));
        run(sector_guard_pkg::CMD_GUARD_PROG, 64'h0, 1'b1);
        op(sector_guard_pkg::CMD_LOCK_CLEAR);
        idle;
        st(sv(2'h3, 4'ha));
        op(sector_guard_pkg::CMD_CLEAR_STATUS);
        pw = {$urandom, $urandom};
        run(sector_guard_pkg::CMD_PWD_PROG, pw, 1'b1);
        idle;
        run(sector_guard_pkg::CMD_PWD_PROG, '1, 1'b1);
        idle;
        op(sector_guard_pkg::CMD_PWD_READ);
        i_host.xfer(sector_guard_pkg::REG_RESULT_LO, 32'h0, 1'b0, lo);
        i_host.xfer(sector_guard_pkg::REG_RESULT_HI, 32'h0, 1'b0, q);
        chk({q, lo}, pw);
        run(sector_guard_pkg::CMD_GUARD_PROG, 64'h2, 1'b1);
        st(sv(2'h1, 4'h9));
        idle;
        rr(sector_guard_pkg::CMD_GUARD_READ, 32'h2);
        run(sector_guard_pkg::CMD_GUARD_PROG, 64'h4, 1'b1);
        idle;
        st(sv(2'h1, 4'ha));
        op(sector_guard_pkg::CMD_CLEAR_STATUS);
        run(sector_guard_pkg::CMD_PWD_PROG, 64'h0, 1'b1);
        hw;
        st(sv(2'h1, 4'h0));
        run(sector_guard_pkg::CMD_PWD_UNLOCK, pw ^ 64'h1, 1'b0);
        st(sv(2'h1, 4'h3));
        idle;
        chk(n >= 3198 && n <= 4800, 1'b1);
        op(sector_guard_pkg::CMD_CLEAR_STATUS);
        run(sector_guard_pkg::CMD_PWD_UNLOCK, pw, 1'b0);
        idle;
        chk(n <= 1, 1'b1);
        st(sv(2'h1, 4'h8));
        report_and_stop;
    end
endmodule // sector_guard_tb_top
`default_nettype wire
